// *** sfp_pkg.sv ***
package sfp_pkg;

    // ------------------------------------------------------------------
    // status register layout
    // ------------------------------------------------------------------
    localparam int          BYTE_W       = 8;
    localparam int          LANES        = 4;
    localparam int          SR_SPE_BIT   = 7;
    localparam int          SR_QUAD_BIT  = 6;
    localparam int          SR_BP_HI     = 5;
    localparam int          SR_BP_LO     = 2;
    localparam logic [7:0]  SR_RESET     = 8'h00;
    localparam logic        RPS_RESET    = 1'h0;

    // ------------------------------------------------------------------
    // data line drive patterns, active low enables
    // ------------------------------------------------------------------
    localparam logic [3:0]  OE_N_NONE    = 4'hF;
    localparam logic [3:0]  OE_N_SINGLE  = 4'hD;
    localparam logic [3:0]  OE_N_DUAL    = 4'hC;
    localparam logic [3:0]  OE_N_QUAD    = 4'h0;

    // ------------------------------------------------------------------
    // link bit counter steps
    // ------------------------------------------------------------------
    localparam logic [2:0]  STEP_1       = 3'h1;
    localparam logic [2:0]  STEP_2       = 3'h2;
    localparam logic [2:0]  STEP_4       = 3'h4;

    typedef enum logic [2:0] {
        LANE_1 = 3'h1,
        LANE_2 = 3'h2,
        LANE_4 = 3'h4
    } lane_t;

    typedef enum logic [4:0] {
        ST_UNARMED = 5'h01,
        ST_STANDBY = 5'h02,
        ST_ACTIVE  = 5'h04,
        ST_PAUSED  = 5'h08,
        ST_HWRST   = 5'h10
    } pin_state_t;

    typedef struct packed {
        lane_t       lanes;
        logic        out_phase;
        logic [7:0]  tx_byte;
    } link_cfg_t;

    typedef struct packed {
        logic        status_protect_enable_bit;
        logic        quad_enable_bit;
        logic [3:0]  block_protect_bits;
        logic [1:0]  aux;
    } status_t;

endpackage

// *** sfp_sync2.sv ***
`timescale 1ns/10ps
module sfp_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            meta <= {W{1'b0}};
            o_q  <= {W{1'b0}};
        end else if (i_ce) begin
            meta <= i_d;
            o_q  <= meta;
        end
    end

endmodule // sfp_sync2

// *** sfp_link_shift.sv ***
`timescale 1ns/10ps
module sfp_link_shift (
    input  wire logic               i_sck,
    input  wire logic               i_rst,
    input  wire logic               i_clr,
    input  wire logic               i_en,
    input  wire sfp_pkg::link_cfg_t i_cfg,
    input  wire logic [3:0]         i_dq,
    output logic      [3:0]         o_dq,
    output logic      [3:0]         o_dq_oe_n,
    output logic      [7:0]         o_byte,
    output logic                    o_tog
);

    // ------------------------------------------------------------------
    // inbound shifting on rising edges
    // ------------------------------------------------------------------
    logic [7:0]          isr;
    logic [2:0]          icnt;
    logic [7:0]          next_isr;
    logic [2:0]          step;
    logic [3:0]          sum;
    logic [7:0]          osr;
    sfp_pkg::lane_t      olanes;
    logic                ophase;
    logic [7:0]          word;
    logic                hiz;

    // inbound width follows the shape latched at the byte start
    always_comb begin
        next_isr = isr;
        step     = sfp_pkg::STEP_1;
        unique case (olanes)
            sfp_pkg::LANE_1: begin
                next_isr = {isr[6:0], i_dq[0]};
                step     = sfp_pkg::STEP_1;
            end
            sfp_pkg::LANE_2: begin
                next_isr = {isr[5:0], i_dq[1:0]};
                step     = sfp_pkg::STEP_2;
            end
            sfp_pkg::LANE_4: begin
                next_isr = {isr[3:0], i_dq};
                step     = sfp_pkg::STEP_4;
            end
            default: begin
                next_isr = isr;
                step     = sfp_pkg::STEP_1;
            end
        endcase
    end

    assign sum = {1'b0, icnt} + {1'b0, step};

    always_ff @(posedge i_sck or posedge i_clr) begin
        if (i_clr) begin
            isr  <= 8'h00;
            icnt <= 3'h0;
        end else if (i_en) begin
            isr  <= next_isr;
            icnt <= sum[2:0];
        end
    end

    // completed byte survives the end of the frame for the slow side
    always_ff @(posedge i_sck or posedge i_rst) begin
        if (i_rst) begin
            o_byte <= 8'h00;
            o_tog  <= 1'b0;
        end else if (!i_clr && i_en && sum[3]) begin
            o_byte <= next_isr;
            o_tog  <= ~o_tog;
        end
    end

    // ------------------------------------------------------------------
    // outbound shifting on falling edges
    // ------------------------------------------------------------------
    assign word = (icnt == 3'h0) ? i_cfg.tx_byte : osr;
    assign hiz  = i_clr | ~i_en;

    always_ff @(negedge i_sck or posedge i_clr) begin
        if (i_clr) begin
            osr    <= 8'h00;
            olanes <= sfp_pkg::LANE_1;
            ophase <= 1'b0;
        end else if (i_en) begin
            if (icnt == 3'h0) begin
                olanes <= i_cfg.lanes;
                ophase <= i_cfg.out_phase;
            end
            unique case ((icnt == 3'h0) ? i_cfg.lanes : olanes)
                sfp_pkg::LANE_2: osr <= {word[5:0], 2'h0};
                sfp_pkg::LANE_4: osr <= {word[3:0], 4'h0};
                default:         osr <= {word[6:0], 1'h0};
            endcase
        end
    end

    // drivers open only in the output phase, closed at once on pause
    always_ff @(negedge i_sck or posedge hiz) begin
        if (hiz) begin
            o_dq_oe_n <= sfp_pkg::OE_N_NONE;
            o_dq      <= 4'h0;
        end else if (!((icnt == 3'h0) ? i_cfg.out_phase : ophase)) begin
            o_dq_oe_n <= sfp_pkg::OE_N_NONE;
            o_dq      <= 4'h0;
        end else begin
            unique case ((icnt == 3'h0) ? i_cfg.lanes : olanes)
                sfp_pkg::LANE_2: begin
                    o_dq_oe_n <= sfp_pkg::OE_N_DUAL;
                    o_dq      <= {2'h0, word[7:6]};
                end
                sfp_pkg::LANE_4: begin
                    o_dq_oe_n <= sfp_pkg::OE_N_QUAD;
                    o_dq      <= word[7:4];
                end
                default: begin
                    o_dq_oe_n <= sfp_pkg::OE_N_SINGLE;
                    o_dq      <= {2'h0, word[7], 1'h0};
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_idle_no_drive: assert property (
        @(negedge i_sck) disable iff (i_clr || !i_en)
        (icnt == 3'h0 && !i_cfg.out_phase) |=> (o_dq_oe_n == 4'hF))
        else $error("data lines driven outside output phase");

    chk_quad_drive: assert property (
        @(negedge i_sck) disable iff (i_clr || !i_en)
        (icnt == 3'h0 && i_cfg.out_phase && i_cfg.lanes == sfp_pkg::LANE_4)
        |=> (o_dq_oe_n == 4'h0 && o_dq == $past(i_cfg.tx_byte[7:4])))
        else $error("quad output nibble wrong");

    chk_single_byte: assert property (
        @(posedge i_sck) disable iff (i_clr || i_rst)
        (i_en && olanes == sfp_pkg::LANE_1 && icnt == 3'h7)
        |=> (o_tog != $past(o_tog) && o_byte[0] == $past(i_dq[0])))
        else $error("single line byte not completed");

    chk_pause_hiz: assert property (
        @(posedge i_sck) disable iff (i_clr)
        !i_en |-> (o_dq_oe_n == 4'hF))
        else $error("drivers open during pause");

    cov_quad_out: cover property (
        @(negedge i_sck) (o_dq_oe_n == 4'h0));

endmodule // sfp_link_shift

// *** sfp_pin_ctrl.sv ***
`timescale 1ns/10ps
// Functional notes
// - Chip select high: deselected, outputs high impedance, standby.
// - Chip select low: device active, accepts instructions and data.
// - After reset, nothing accepted before a high-to-low chip select edge.
// - Single mode: input line sampled on rising serial clock edges.
// - Single mode: read data driven on output line at falling edges.
// - Dual/quad: shared lines sample on rising, drive on falling edges.
// - Quad transfers use write-protect and pause pins as lines 2 and 3.
// - Protect bit set and write-protect low: protected status bits refused.
// - Protect bit clear: status writes allowed whatever the pin level.
// - Quad enable set: write-protect function off, pin is data line 2.
// - Quad enable set: pause and reset functions off, pin is line 3.
// - Quad off: fourth pin is pause if select bit 0, reset if 1.
// - Pause low while selected: output tri-stated, sequence held.
// - Reset input low: reset mode with outputs high impedance.
module sfp_pin_ctrl (
    input  wire logic               I_CLK,
    input  wire logic               I_NRST,
    input  wire logic               I_CE,
    input  wire logic               I_SCK,
    input  wire logic               I_CS_N,
    input  wire logic [3:0]         I_DQ,
    output logic      [3:0]         O_DQ,
    output logic      [3:0]         O_DQ_OE_N,
    input  wire sfp_pkg::link_cfg_t I_CFG,
    input  wire logic               I_SR_WR,
    input  wire logic [7:0]         I_SR_WDATA,
    input  wire logic               I_RPS_WR,
    input  wire logic               I_RPS_WDATA,
    output logic      [7:0]         O_STATUS,
    output logic                    O_RPS,
    output logic                    O_SR_WR_REJECT,
    output logic      [7:0]         O_RX_BYTE,
    output logic                    O_RX_VALID,
    output logic                    O_STANDBY,
    output logic                    O_PAUSED,
    output logic                    O_HW_RESET,
    output logic                    O_WP_LOCKED
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    sfp_pkg::status_t     sr;
    logic                 rps;
    sfp_pkg::pin_state_t  state;
    sfp_pkg::pin_state_t  next_state;
    sfp_pkg::link_cfg_t   cfg;
    logic [3:0]           sync_q;
    logic                 cs_n_s;
    logic                 wp_s;
    logic                 dq3_s;
    logic                 tog_s;
    logic                 tog_seen;
    logic                 byte_evt;
    logic                 link_tog;
    logic [7:0]           link_byte;
    logic                 link_ok;
    logic                 link_rst;
    logic                 link_clr;
    logic                 link_en;
    logic                 pause_sel;
    logic                 reset_sel;
    logic                 pause_s;
    logic                 hw_rst_s;
    logic                 wp_low;
    logic                 protected_sr;
    logic                 rx_valid;
    logic [7:0]           rx_byte;
    logic                 reject;
    logic                 standby;
    logic                 paused;
    logic                 hw_reset;
    logic                 wp_locked;

    // ------------------------------------------------------------------
    // pin and link event synchronisers
    // ------------------------------------------------------------------
    sfp_sync2 #(
        .W(4)
    ) u_sync (
        .i_clk  (I_CLK),
        .i_nrst (I_NRST),
        .i_ce   (I_CE),
        .i_d    ({link_tog, I_DQ[3], I_DQ[2], I_CS_N}),
        .o_q    (sync_q)
    );

    assign cs_n_s = sync_q[0];
    assign wp_s   = sync_q[1];
    assign dq3_s  = sync_q[2];
    assign tog_s  = sync_q[3];

    // ------------------------------------------------------------------
    // shared pin function selection
    // ------------------------------------------------------------------
    assign pause_sel    = ~sr.quad_enable_bit & ~rps;
    assign reset_sel    = ~sr.quad_enable_bit & rps;
    assign pause_s      = pause_sel & ~dq3_s;
    assign hw_rst_s     = reset_sel & ~dq3_s;
    assign wp_low       = ~sr.quad_enable_bit & ~wp_s;
    assign protected_sr = sr.status_protect_enable_bit & wp_low;

    // ------------------------------------------------------------------
    // link side: runs on the serial clock, ended by chip select
    // ------------------------------------------------------------------
    assign link_clr = I_CS_N | link_rst
                    | (reset_sel & ~I_DQ[3]);
    assign link_en  = link_ok & ~(pause_sel & ~I_DQ[3]);

    sfp_link_shift u_link (
        .i_sck     (I_SCK),
        .i_rst     (link_rst),
        .i_clr     (link_clr),
        .i_en      (link_en),
        .i_cfg     (cfg),
        .i_dq      (I_DQ),
        .o_dq      (O_DQ),
        .o_dq_oe_n (O_DQ_OE_N),
        .o_byte    (link_byte),
        .o_tog     (link_tog)
    );

    // ------------------------------------------------------------------
    // link reset and transfer shape held for the link side
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            link_rst <= 1'b1;
        end else if (I_CE) begin
            link_rst <= 1'b0;
        end
    end

    // shape is registered here; the link latches it at each byte start
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            cfg <= {sfp_pkg::LANE_1, 1'b0, 8'h00};
        end else if (I_CE) begin
            cfg <= I_CFG;
        end
    end

    // ------------------------------------------------------------------
    // pin state machine
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (hw_rst_s) begin
            next_state = sfp_pkg::ST_HWRST;
        end else begin
            unique case (state)
                sfp_pkg::ST_UNARMED: begin
                    if (cs_n_s) begin
                        next_state = sfp_pkg::ST_STANDBY;
                    end
                end
                sfp_pkg::ST_STANDBY: begin
                    if (!cs_n_s) begin
                        next_state = sfp_pkg::ST_ACTIVE;
                    end
                end
                sfp_pkg::ST_ACTIVE: begin
                    if (cs_n_s) begin
                        next_state = sfp_pkg::ST_STANDBY;
                    end else if (pause_s) begin
                        next_state = sfp_pkg::ST_PAUSED;
                    end
                end
                sfp_pkg::ST_PAUSED: begin
                    if (cs_n_s) begin
                        next_state = sfp_pkg::ST_STANDBY;
                    end else if (!pause_s) begin
                        next_state = sfp_pkg::ST_ACTIVE;
                    end
                end
                sfp_pkg::ST_HWRST: begin
                    next_state = sfp_pkg::ST_UNARMED;
                end
                default: begin
                    next_state = sfp_pkg::ST_UNARMED;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            state <= sfp_pkg::ST_UNARMED;
        end else if (I_CE) begin
            state <= next_state;
        end
    end

    // link may only run once a deselect has been seen; held in a frame unless the reset input clears it
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            link_ok <= 1'b0;
        end else if (I_CE) begin
            if (hw_rst_s) begin
                link_ok <= 1'b0;
            end else if (cs_n_s) begin
                link_ok <= (next_state == sfp_pkg::ST_STANDBY);
            end
        end
    end

    // ------------------------------------------------------------------
    // mode outputs
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            standby   <= 1'b1;
            paused    <= 1'b0;
            hw_reset  <= 1'b0;
            wp_locked <= 1'b0;
        end else if (I_CE) begin
            standby   <= (next_state == sfp_pkg::ST_STANDBY)
                       | (next_state == sfp_pkg::ST_UNARMED)
                       | (next_state == sfp_pkg::ST_HWRST);
            paused    <= (next_state == sfp_pkg::ST_PAUSED);
            hw_reset  <= (next_state == sfp_pkg::ST_HWRST);
            wp_locked <= protected_sr;
        end
    end

    // ------------------------------------------------------------------
    // inbound bytes handed to the core
    // ------------------------------------------------------------------
    assign byte_evt = (tog_s != tog_seen);

    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            tog_seen <= 1'b0;
            rx_valid <= 1'b0;
            rx_byte  <= 8'h00;
        end else if (I_CE) begin
            tog_seen <= tog_s;
            rx_valid <= byte_evt & link_ok;
            if (byte_evt && link_ok) begin
                rx_byte <= link_byte;
            end
        end
    end

    // ------------------------------------------------------------------
    // status register and pin select bit
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            sr     <= sfp_pkg::SR_RESET;
            reject <= 1'b0;
        end else if (I_CE) begin
            reject <= I_SR_WR & protected_sr;
            if (I_SR_WR) begin
                if (protected_sr) begin
                    sr.aux <= I_SR_WDATA[1:0];
                end else begin
                    sr <= I_SR_WDATA;
                end
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            rps <= sfp_pkg::RPS_RESET;
        end else if (I_CE && I_RPS_WR) begin
            rps <= I_RPS_WDATA;
        end
    end

    assign O_STATUS       = sr;
    assign O_RPS          = rps;
    assign O_SR_WR_REJECT = reject;
    assign O_RX_BYTE      = rx_byte;
    assign O_RX_VALID     = rx_valid;
    assign O_STANDBY      = standby;
    assign O_PAUSED       = paused;
    assign O_HW_RESET     = hw_reset;
    assign O_WP_LOCKED    = wp_locked;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_NRST);

    chk_unarmed_no_rx: assert property (
        (I_CE && !link_ok) |=> !O_RX_VALID)
        else $error("byte delivered before chip select edge");

    chk_protect_reject: assert property (
        (I_CE && I_SR_WR && protected_sr)
        |=> (O_SR_WR_REJECT && O_STATUS[7:2] == $past(O_STATUS[7:2])))
        else $error("protected status bits were changed");

    chk_open_write: assert property (
        (I_CE && I_SR_WR && !sr.status_protect_enable_bit)
        |=> (O_STATUS == $past(I_SR_WDATA) && !O_SR_WR_REJECT))
        else $error("unprotected status write lost");

    chk_quad_no_wp: assert property (
        (I_CE && sr.quad_enable_bit) |=> !O_WP_LOCKED)
        else $error("write protect active in quad mode");

    chk_quad_no_pause: assert property (
        (I_CE && sr.quad_enable_bit) |=> (!O_PAUSED && !O_HW_RESET))
        else $error("pause or reset active in quad mode");

    chk_reset_enter: assert property (
        (I_CE && hw_rst_s) |=> (O_HW_RESET && !link_ok))
        else $error("reset input did not enter reset mode");

    chk_deselect_standby: assert property (
        (I_CE && cs_n_s && !hw_rst_s) |=> O_STANDBY ##1 !O_PAUSED)
        else $error("deselected device not in standby");

    chk_pause_enter: assert property (
        (I_CE && !cs_n_s && pause_s && !hw_rst_s
         && state == sfp_pkg::ST_ACTIVE) |=> O_PAUSED)
        else $error("pause not entered");

    chk_select_active: assert property (
        (I_CE && !cs_n_s && !hw_rst_s
         && state == sfp_pkg::ST_STANDBY) |=> !O_STANDBY)
        else $error("selected device stayed in standby");

    chk_rps_no_pause: assert property (
        (I_CE && O_RPS)
        |=> !O_PAUSED)
        else $error("pause entered with reset selected");

    cov_reject: cover property (I_SR_WR && protected_sr ##1 O_SR_WR_REJECT);
    cov_hw_reset: cover property (O_HW_RESET ##1 !O_HW_RESET);
    cov_rx_byte: cover property (O_RX_VALID && state == sfp_pkg::ST_ACTIVE);
    cov_pause: cover property (O_PAUSED ##1 !O_PAUSED);

endmodule // sfp_pin_ctrl

// *** sfp_host.sv ***
`timescale 1ns/10ps
module sfp_host (
    output logic            o_sck,
    output logic            o_cs_n,
    output logic      [3:0] o_dq,
    input  wire logic [3:0] i_dq,
    input  wire logic [3:0] i_dq_oe_n
);
    logic [3:0] drv;
    logic [3:0] drv_oe_n;

    // released lines: 2 and 3 pulled up, 0 and 1 show the inverse
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            if (!i_dq_oe_n[k])
                o_dq[k] = i_dq[k];
            else if (!drv_oe_n[k])
                o_dq[k] = drv[k];
            else
                o_dq[k] = (k > 1) ? 1'b1 : ~drv[k];
        end
    end

    // select starts low so the first frame comes before any high level
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b0;
        drv = 4'hF;
        drv_oe_n = 4'hF;
    end

    task automatic put(input logic [3:0] d, input logic [3:0] oe_n);
        drv = d;
        drv_oe_n = oe_n;
    endtask

    // mode 0 clock, runs only inside tasks; capture on the rise
    task automatic pulse(output logic [3:0] q, output logic [3:0] oe);
        #80 o_sck = 1'b1;
        q = o_dq;
        oe = i_dq_oe_n;
        #80 o_sck = 1'b0;
    endtask

    task automatic select(input logic on);
        #40 o_cs_n = ~on;
    endtask
endmodule // sfp_host

// *** sfp_pin_ctrl_tb.sv ***
`timescale 1ns/10ps
module sfp_pin_ctrl_tb;
    logic               I_CLK = 1'b0;
    logic               I_NRST = 1'b0;
    logic               I_SR_WR = 1'b0;
    logic               I_RPS_WR = 1'b0;
    logic               I_RPS_WDATA = 1'b0;
    logic [7:0]         I_SR_WDATA = 8'h00;
    sfp_pkg::link_cfg_t I_CFG = {sfp_pkg::LANE_1, 1'b0, 8'h00};
    logic               sck, cs_n, rej_seen, rps, rst, wpl;
    logic [3:0]         dq_in, dq_out, oe_n;
    logic [7:0]         O_STATUS, O_RX_BYTE, rx_last, sr, v, b;
    logic               stb, rej, rxv, psd;
    int                 n_errors = 0, num_checks = 0, rx_cnt = 0;
    logic [31:0]        seed = 32'h50;

    always #50 I_CLK = ~I_CLK;

    sfp_pin_ctrl dut (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_CE(1'b1),
        .I_SCK(sck), .I_CS_N(cs_n), .I_DQ(dq_in), .O_DQ(dq_out),
        .O_DQ_OE_N(oe_n), .I_CFG(I_CFG), .I_SR_WR(I_SR_WR),
        .I_SR_WDATA(I_SR_WDATA), .I_RPS_WR(I_RPS_WR),
        .I_RPS_WDATA(I_RPS_WDATA), .O_STATUS(O_STATUS), .O_RPS(rps),
        .O_SR_WR_REJECT(rej), .O_RX_BYTE(O_RX_BYTE), .O_RX_VALID(rxv),
        .O_STANDBY(stb), .O_PAUSED(psd), .O_HW_RESET(rst),
        .O_WP_LOCKED(wpl));
    sfp_host host (.o_sck(sck), .o_cs_n(cs_n), .o_dq(dq_in),
        .i_dq(dq_out), .i_dq_oe_n(oe_n));

    always @(posedge I_CLK) begin
        if (rxv === 1'b1) begin
            rx_last <= O_RX_BYTE;
            rx_cnt <= rx_cnt + 1;
        end
        if (rej === 1'b1)
            rej_seen <= 1'b1;
    end

    function logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    function logic locked(input logic wp);
        return sr[7] & ~sr[6] & ~wp;
    endfunction

    task automatic compare(input string what, input logic [7:0] exp,
                           input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge I_CLK);
    endtask

    task automatic frame(input logic on);
        host.select(on);
        #1 if (!on) compare("oe_n", 8'h0F, {4'h0, oe_n});
        tick(4);
    endtask

    task automatic pins(input logic wp, input logic p3);
        host.put({p3, wp, host.drv[1:0]}, {p3, wp, host.drv_oe_n[1:0]});
    endtask

    task automatic send(input logic [7:0] d);
        logic [3:0] q, oe;
        for (int i = 7; i >= 0; i--) begin
            host.put({host.drv[3:1], d[i]}, {host.drv_oe_n[3:1], 1'b0});
            host.pulse(q, oe);
            compare("oe_n", 8'h0F, {4'h0, oe});
        end
    endtask

    task automatic fetch(input int lanes, input logic [3:0] exp_oe);
        logic [3:0] q, oe;
        v = 8'h00;
        for (int i = 0; i < 8 / lanes; i++) begin
            host.pulse(q, oe);
            compare("oe_n", {4'h0, exp_oe}, {4'h0, oe});
            v = (lanes == 1) ? {v[6:0], q[1]} : {v[3:0], q};
        end
    endtask

    task automatic sr_write(input logic wp, input logic [7:0] d);
        logic lock;
        lock = locked(wp);
        pins(wp, 1'b1);
        tick(4);
        compare("wp_locked", {7'h0, lock}, {7'h0, wpl});
        rej_seen = 1'b0;
        I_SR_WR = 1'b1;
        I_SR_WDATA = d;
        tick(1);
        I_SR_WR = 1'b0;
        tick(3);
        sr = lock ? {sr[7:2], d[1:0]} : d;
        compare("status", sr, O_STATUS);
        compare("reject", {7'h0, lock}, {7'h0, rej_seen});
    endtask

    initial begin
        repeat (6000) @(posedge I_CLK);
        n_errors++;
        conclude();
    end

    initial begin
        sr = 8'h00;
        tick(4);
        compare("standby", 8'h01, {7'h0, stb});
        compare("status", 8'h00, O_STATUS);
        compare("rps", 8'h00, {7'h0, rps});
        I_NRST = 1'b1;
        send(8'hA5);
        tick(6);
        compare("rx_count", 8'h00, rx_cnt[7:0]);
        frame(1'b0);
        compare("standby", 8'h01, {7'h0, stb});
        frame(1'b1);
        compare("standby", 8'h00, {7'h0, stb});
        b = rnd();
        send(b);
        tick(6);
        compare("rx_byte", b, rx_last);
        frame(1'b0);
        $display("test select_receive done");
        b = rnd();
        I_CFG = {sfp_pkg::LANE_1, 1'b1, b};
        frame(1'b1);
        send(rnd());
        fetch(1, 4'hD);
        compare("read_single", b, v);
        frame(1'b0);
        $display("test single_read done");
        sr_write(1'b1, 8'h80);
        sr_write(1'b0, rnd() | 8'h40);
        sr_write(1'b1, 8'h00);
        sr_write(1'b0, 8'hBC);
        sr_write(1'b0, 8'hC0);
        sr_write(1'b1, 8'hC0);
        sr_write(1'b0, 8'h40);
        $display("test status_protect done");
        b = rnd();
        I_CFG = {sfp_pkg::LANE_4, 1'b1, b};
        frame(1'b1);
        send(rnd());
        host.put(4'hF, 4'hF);
        fetch(4, 4'h0);
        compare("read_quad", b, v);
        frame(1'b0);
        I_CFG = {sfp_pkg::LANE_1, 1'b0, 8'h00};
        frame(1'b1);
        pins(1'b1, 1'b0);
        tick(6);
        compare("pause_reset", 8'h00, {6'h0, psd, rst});
        pins(1'b1, 1'b1);
        frame(1'b0);
        $display("test quad done");
        sr_write(1'b1, 8'h00);
        frame(1'b1);
        pins(1'b1, 1'b0);
        tick(6);
        compare("paused", 8'h01, {7'h0, psd});
        compare("oe_n", 8'h0F, {4'h0, oe_n});
        pins(1'b1, 1'b1);
        tick(6);
        compare("paused", 8'h00, {7'h0, psd});
        frame(1'b0);
        I_RPS_WR = 1'b1;
        I_RPS_WDATA = 1'b1;
        tick(1);
        I_RPS_WR = 1'b0;
        tick(2);
        compare("rps", 8'h01, {7'h0, rps});
        pins(1'b1, 1'b0);
        tick(6);
        compare("pause_reset", 8'h01, {6'h0, psd, rst});
        pins(1'b1, 1'b1);
        tick(6);
        compare("hw_reset", 8'h00, {7'h0, rst});
        $display("test pause_reset done");
        conclude();
    end
endmodule // sfp_pin_ctrl_tb
